// ===== verilog/coupled_ram_wrapper.v
/*
  Wrapper between the CPU data memory port and two interleaved banks.
  Passes data and check codes, watches the CPU error events, checks
  address parity, decodes twice and fills both banks on request.
  Assumes the CPU does the correction itself and reports errors on its
  event bus one or more cycles after the read data is delivered.
*/
// Contract
// - Slave only; answers every CPU access
// - Reads return 64-bit word plus 8-bit code
// - Writes store the CPU check code alongside
// - Separate single-bit and multibit error interrupts
// - Capture failing addresses and error flags
// - Check parity on every incoming address
// - Decode selects twice and compare
// - Two byte-interleaved banks, independent controls
// - Auto-initialize both banks including check bits
// - Provide access information for a trace unit
`timescale 1ns/1ps
`default_nettype none
`include "coupled_ram_map.vh"

module coupled_ram_wrapper #(
  parameter AW = `ADDR_WIDTH,      // CPU word address width
  parameter BW = `BANK_ADDR_WIDTH  // Bank address width
) (
  input  wire                     clk,          // System clock
  input  wire                     rst_n,        // Async reset, low
  input  wire                     cpu_req,      // Access request
  input  wire                     cpu_we,       // Write when high
  input  wire [AW-1:0]            cpu_addr,     // Word address
  input  wire                     cpu_addr_par, // Address parity bit
  input  wire [`WORD_BYTES-1:0]   cpu_be,       // Byte write enables
  input  wire [`WORD_WIDTH-1:0]   cpu_wdata,    // Write data
  input  wire [`ECC_WIDTH-1:0]    cpu_wecc,     // Write check code
  output wire                     cpu_ready,    // Access accepted
  output reg                      cpu_rvalid,   // Read data valid
  output wire [`WORD_WIDTH-1:0]   cpu_rdata,    // Read data
  output wire [`ECC_WIDTH-1:0]    cpu_recc,     // Read check code
  input  wire                     evt_single,   // CPU single-bit event
  input  wire                     evt_multi,    // CPU multibit event
  input  wire                     single_clr,   // Clear single flag
  input  wire                     multi_clr,    // Clear multibit flag
  output wire                     single_irq,   // Single-bit interrupt
  output wire                     multi_irq,    // Multibit interrupt
  output reg  [AW-1:0]            single_addr,  // Single-bit address
  output reg  [AW-1:0]            multi_addr,   // Multibit address
  input  wire                     fault_clr,    // Clear address faults
  output wire                     par_err,      // Parity fault flag
  output wire                     dec_err,      // Decode fault flag
  output wire                     sys_err,      // To error signaling
  input  wire                     init_start,   // Start auto-init
  output wire                     init_busy,    // Auto-init running
  output reg                      init_done,    // Auto-init finished
  output reg                      trc_valid,    // Trace: access seen
  output reg                      trc_we,       // Trace: write
  output reg  [AW-1:0]            trc_addr,     // Trace: address
  output reg  [`WORD_BYTES-1:0]   trc_be        // Trace: byte enables
);

  reg              state_reg;
  reg              state_next;
  reg  [BW-1:0]    fill_reg;
  reg  [BW-1:0]    fill_next;
  reg              single_reg;
  reg              multi_reg;
  reg              par_err_reg;
  reg              dec_err_reg;
  reg  [AW-1:0]    rd_addr_reg;
  wire             dec_fault;
  // Fill engine state codes; one bit is enough for two states
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_FILL = 1'b1;

  wire             acc;
  wire             par_bad;
  wire [`SEL_WIDTH-1:0] sel_a;
  wire [`SEL_WIDTH-1:0] sel_b;

  // Bank-side controls, muxed between CPU and fill engine
  reg                    b_we;
  reg  [BW-1:0]          b_addr;
  reg  [`WORD_WIDTH-1:0] b_wdata;
  reg  [`ECC_WIDTH-1:0]  b_wecc;
  reg                    cs0;
  reg                    cs1;
  reg  [`BANK_LANES-1:0] wbe0;
  reg  [`BANK_LANES-1:0] wbe1;
  wire [`BANK_WIDTH-1:0] wd0;
  wire [`BANK_WIDTH-1:0] wd1;
  wire [`BANK_WIDTH-1:0] rd0;
  wire [`BANK_WIDTH-1:0] rd1;

  // Lane enables of one bank: its four bytes plus the check nibble
  function [`BANK_LANES-1:0] lane_en;
    input [`WORD_BYTES-1:0] be;
    input                   odd;
    input                   ecc;
    begin
      lane_en = odd ? {ecc, be[7], be[5], be[3], be[1]}
                    : {ecc, be[6], be[4], be[2], be[0]};
    end
  endfunction

  // CPU is only stalled while the fill engine owns the banks
  assign cpu_ready = (state_reg == ST_IDLE);
  assign acc       = cpu_req & cpu_ready;
  assign init_busy = (state_reg == ST_FILL);

  // Parity over address and parity bit must match the sense
  assign par_bad = acc &
    ((^{cpu_addr, cpu_addr_par}) != `ADDR_PAR_ODD);

  // Two independent decoder copies feed the comparison
  addr_decoder #(.AW(AW), .BW(BW)) u_dec_a (
    .req  (acc),
    .we   (cpu_we),
    .addr (cpu_addr),
    .sel  (sel_a)
  );
  addr_decoder #(.AW(AW), .BW(BW)) u_dec_b (
    .req  (acc),
    .we   (cpu_we),
    .addr (cpu_addr),
    .sel  (sel_b)
  );

  // Any disagreement means one decoder is faulty
  assign dec_fault = (sel_a != sel_b);

  // Bank access mux: fill engine writes every lane of both banks
  always @*
  begin
    if (state_reg == ST_FILL)
    begin
      b_we    = 1'b1;
      b_addr  = fill_reg;
      b_wdata = `INIT_DATA;
      b_wecc  = `INIT_ECC;
      cs0     = 1'b1;
      cs1     = 1'b1;
      wbe0    = {`BANK_LANES{1'b1}};
      wbe1    = {`BANK_LANES{1'b1}};
    end
    else
    begin
      b_we    = cpu_we;
      b_addr  = cpu_addr[BW-1:0];
      b_wdata = cpu_wdata;
      b_wecc  = cpu_wecc;
      cs0     = sel_a[`SEL_CS0];
      cs1     = sel_b[`SEL_CS1];
      wbe0    = lane_en(cpu_be, 1'b0, sel_a[`SEL_ECC]);
      wbe1    = lane_en(cpu_be, 1'b1, sel_b[`SEL_ECC]);
    end
  end

  // Byte interleave: even bytes to bank 0, odd bytes to bank 1
  genvar g;
  generate
    for (g = 0; g < `BANK_DATA_BYTES; g = g + 1)
    begin : g_ilv
      assign wd0[8*g +: 8] = b_wdata[16*g +: 8];
      assign wd1[8*g +: 8] = b_wdata[16*g + 8 +: 8];
      assign cpu_rdata[16*g +: 8]     = rd0[8*g +: 8];
      assign cpu_rdata[16*g + 8 +: 8] = rd1[8*g +: 8];
    end
  endgenerate

  // Check code split: low nibble in bank 0, high nibble in bank 1
  assign wd0[`BANK_WIDTH-1 -: `BANK_ECC_BITS] = b_wecc[3:0];
  assign wd1[`BANK_WIDTH-1 -: `BANK_ECC_BITS] = b_wecc[7:4];
  assign cpu_recc = {rd1[`BANK_WIDTH-1 -: `BANK_ECC_BITS],
                     rd0[`BANK_WIDTH-1 -: `BANK_ECC_BITS]};

  ram_bank #(.BW(BW)) u_bank0 (
    .clk   (clk),
    .rst_n (rst_n),
    .cs    (cs0),
    .we    (b_we),
    .wbe   (wbe0),
    .addr  (b_addr),
    .wdata (wd0),
    .rdata (rd0)
  );
  ram_bank #(.BW(BW)) u_bank1 (
    .clk   (clk),
    .rst_n (rst_n),
    .cs    (cs1),
    .we    (b_we),
    .wbe   (wbe1),
    .addr  (b_addr),
    .wdata (wd1),
    .rdata (rd1)
  );

  // Fill engine: walks every row once, then hands back to the CPU
  always @*
  begin
    state_next = state_reg;
    fill_next  = fill_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (init_start)
        begin
          state_next = ST_FILL;
          fill_next  = {BW{1'b0}};
        end
      end
      ST_FILL:
      begin
        fill_next = fill_reg + {{(BW-1){1'b0}}, 1'b1};
        if (&fill_reg)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      fill_reg  <= {BW{1'b0}};
      init_done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      fill_reg  <= fill_next;
      init_done <= (state_reg == ST_FILL) && (&fill_reg);
    end
  end

  // Read answered next cycle; out-of-range reads get held words
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_rvalid  <= 1'b0;
      rd_addr_reg <= {AW{1'b0}};
    end
    else
    begin
      cpu_rvalid <= acc & ~cpu_we;
      if (acc && !cpu_we)
        rd_addr_reg <= cpu_addr;
    end
  end

  // Events refer to the latest read; set beats clear, none is lost
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single_reg  <= 1'b0;
      multi_reg   <= 1'b0;
      single_addr <= {AW{1'b0}};
      multi_addr  <= {AW{1'b0}};
    end
    else
    begin
      if (evt_single)
      begin
        single_reg  <= 1'b1;
        single_addr <= rd_addr_reg;
      end
      else if (single_clr)
        single_reg <= 1'b0;
      if (evt_multi)
      begin
        multi_reg  <= 1'b1;
        multi_addr <= rd_addr_reg;
      end
      else if (multi_clr)
        multi_reg <= 1'b0;
    end
  end

  // Events only arrive once the CPU has enabled them
  assign single_irq = single_reg;
  assign multi_irq  = multi_reg;

  // Address integrity faults are sticky; set wins over clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      par_err_reg <= 1'b0;
      dec_err_reg <= 1'b0;
    end
    else
    begin
      if (par_bad)
        par_err_reg <= 1'b1;
      else if (fault_clr)
        par_err_reg <= 1'b0;
      if (dec_fault)
        dec_err_reg <= 1'b1;
      else if (fault_clr)
        dec_err_reg <= 1'b0;
    end
  end

  assign par_err = par_err_reg;
  assign dec_err = dec_err_reg;
  assign sys_err = par_err_reg | dec_err_reg;

  // Trace view of each accepted access, one cycle late
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trc_valid <= 1'b0;
      trc_we    <= 1'b0;
      trc_addr  <= {AW{1'b0}};
      trc_be    <= {`WORD_BYTES{1'b0}};
    end
    else
    begin
      trc_valid <= acc;
      if (acc)
      begin
        trc_we   <= cpu_we;
        trc_addr <= cpu_addr;
        trc_be   <= cpu_be;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verilog/coupled_ram_map.vh
/*
  Constants for the coupled RAM wrapper: bank geometry, lane layout,
  parity sense and auto-initialization fill.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef COUPLED_RAM_MAP_VH
`define COUPLED_RAM_MAP_VH

// Geometry of one byte-interleaved bank
`define BANK_WIDTH      36
`define BANK_DATA_BYTES 4
`define BANK_ECC_BITS   4
`define BANK_LANES      5
`define BANK_ECC_LANE   4

// CPU word and check code
`define WORD_WIDTH      64
`define ECC_WIDTH       8
`define WORD_BYTES      8

// Default address geometry (64-bit word index)
`define ADDR_WIDTH      16
`define BANK_ADDR_WIDTH 14

// Address parity sense: 0 even, 1 odd
`define ADDR_PAR_ODD    1'b0

// Fill pattern written by auto-initialization
`define INIT_DATA       64'h0000_0000_0000_0000
`define INIT_ECC        8'h00

// Decoder output positions
`define SEL_CS0         0
`define SEL_CS1         1
`define SEL_ECC         2
`define SEL_WIDTH       3

`endif

// ===== verilog/addr_decoder.v
/*
  Address decoder for the bank chip selects and the ECC select.
  Assumes a word address and request strobes synchronous to the clock;
  purely combinational, instantiated twice for a redundant comparison.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coupled_ram_map.vh"

module addr_decoder #(
  parameter AW = `ADDR_WIDTH,     // Word address width
  parameter BW = `BANK_ADDR_WIDTH // Bank depth as address bits
) (
  input  wire          req,   // Access in progress
  input  wire          we,    // Write access
  input  wire [AW-1:0] addr,  // Word address
  output reg  [`SEL_WIDTH-1:0] sel    // ECC select and bank selects
);

  reg in_range;

  // Hit only inside the populated bank range; bits above must be zero
  always @*
  begin
    in_range = ~|(addr >> BW);
    sel                = {`SEL_WIDTH{1'b0}};
    sel[`SEL_CS0]      = req & in_range;
    sel[`SEL_CS1]      = req & in_range;
    sel[`SEL_ECC]      = req & we & in_range;
  end

endmodule
`default_nettype wire

// ===== verilog/ram_bank.v
/*
  One 36-bit bank: four data bytes plus four check bits, with a
  per-lane write enable and a registered read port.
  Assumes one access per clock; contents are not reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coupled_ram_map.vh"

module ram_bank #(
  parameter BW = `BANK_ADDR_WIDTH // Address bits
) (
  input  wire                   clk,    // System clock
  input  wire                   rst_n,  // Async reset, low
  input  wire                   cs,     // Bank chip select
  input  wire                   we,     // Write strobe
  input  wire [`BANK_LANES-1:0] wbe,    // Lane write enables
  input  wire [BW-1:0]          addr,   // Row address
  input  wire [`BANK_WIDTH-1:0] wdata,  // Write data
  output reg  [`BANK_WIDTH-1:0] rdata   // Read data, registered
);

  localparam DEPTH = 1 << BW;

  reg [`BANK_WIDTH-1:0] mem [0:DEPTH-1];

  wire [`BANK_WIDTH-1:0] bit_en;

  genvar i;

  // Widen each byte lane enable to a bit mask
  generate
    for (i = 0; i < `BANK_DATA_BYTES; i = i + 1)
    begin : g_lane
      assign bit_en[8*i +: 8] = {8{wbe[i]}};
    end
  endgenerate

  // Check bits sit above the data bytes; that lane is four bits wide
  assign bit_en[`BANK_WIDTH-1 -: `BANK_ECC_BITS] =
    {`BANK_ECC_BITS{wbe[`BANK_ECC_LANE]}};

  // One process owns the array, so lanes merge by mask, not by drivers
  always @(posedge clk)
  begin
    if (cs && we)
      mem[addr] <= (mem[addr] & ~bit_en) | (wdata & bit_en);
  end

  // Read port holds its last word while idle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= {`BANK_WIDTH{1'b0}};
    else if (cs && !we)
      rdata <= mem[addr];
  end

endmodule
`default_nettype wire

// ===== tb/coupled_ram_wrapper_asserts.sv
/*
  Port timing checks for the coupled RAM wrapper.
  Assumes one clock domain and a shortened bank depth during init.
*/
`timescale 1ns/1ps
`default_nettype none
module coupled_ram_wrapper_asserts #(
  parameter AW = 16, // Word address width
  parameter BW = 14  // Bank address width
) (
  input wire logic          clk,          // Clock
  input wire logic          rst_n,        // Reset, low
  input wire logic          cpu_req,      // Request
  input wire logic          cpu_we,       // Write
  input wire logic [AW-1:0] cpu_addr,     // Address
  input wire logic          cpu_addr_par, // Parity
  input wire logic          cpu_ready,    // Ready
  input wire logic          cpu_rvalid,   // Read valid
  input wire logic          evt_single,   // Single event
  input wire logic          evt_multi,    // Multi event
  input wire logic          single_clr,   // Single clear
  input wire logic          single_irq,   // Single flag
  input wire logic          multi_irq,    // Multi flag
  input wire logic          par_err,      // Parity flag
  input wire logic          dec_err,      // Decode flag
  input wire logic          sys_err,      // Error out
  input wire logic          init_start,   // Init request
  input wire logic          init_busy,    // Init running
  input wire logic          init_done,    // Init finished
  input wire logic          trc_valid,    // Trace valid
  input wire logic          trc_we,       // Trace write
  input wire logic [AW-1:0] trc_addr      // Trace address
);
  // Length of the busy span, checked when it ends
  logic [BW:0] busy_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt <= '0;
    else if (init_busy)
      busy_cnt <= busy_cnt + 1'b1;
    else
      busy_cnt <= '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Accepted reads and accepted accesses with broken address parity
  sequence s_take_rd;
    cpu_req && cpu_ready && !cpu_we;
  endsequence
  sequence s_bad_par;
    cpu_req && cpu_ready && (^{cpu_addr, cpu_addr_par});
  endsequence

  a_read_answer: assert property (s_take_rd |=> cpu_rvalid)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (
    cpu_rvalid |-> $past(cpu_req && cpu_ready && !cpu_we))
    else $error("read valid without a taken read");
  a_trace_info: assert property ((cpu_req && cpu_ready) |=>
    trc_valid && trc_we == $past(cpu_we) && trc_addr == $past(cpu_addr))
    else $error("trace does not follow access");
  a_single_set: assert property (evt_single |=> single_irq)
    else $error("single event not flagged");
  a_multi_set: assert property (evt_multi |=> multi_irq)
    else $error("multibit event not flagged");
  a_single_sticky: assert property (
    single_irq && !single_clr |=> single_irq)
    else $error("single flag lost without clear");
  a_parity_flag: assert property (s_bad_par |=> par_err && sys_err)
    else $error("bad parity not flagged");
  a_sys_err_or: assert property (sys_err == (par_err || dec_err))
    else $error("error output not the flag union");
  a_init_begin: assert property (
    init_start && !init_busy |=> init_busy && !cpu_ready)
    else $error("init did not start");
  a_init_span: assert property (
    $fell(init_busy) |-> init_done && busy_cnt == (1 << BW))
    else $error("init span length wrong");
endmodule

bind coupled_ram_wrapper coupled_ram_wrapper_asserts #(.AW(AW), .BW(BW)) u_chk (
  .clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_we(cpu_we),
  .cpu_addr(cpu_addr), .cpu_addr_par(cpu_addr_par), .cpu_ready(cpu_ready),
  .cpu_rvalid(cpu_rvalid), .evt_single(evt_single), .evt_multi(evt_multi),
  .single_clr(single_clr), .single_irq(single_irq), .multi_irq(multi_irq),
  .par_err(par_err), .dec_err(dec_err), .sys_err(sys_err),
  .init_start(init_start), .init_busy(init_busy), .init_done(init_done),
  .trc_valid(trc_valid), .trc_we(trc_we), .trc_addr(trc_addr));
`default_nettype wire

// ===== tb/cpu_port_model.sv
/*
  Behavioural CPU data memory port and event bus.
  Assumes the wrapper answers reads by the negedge after the taking edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_port_model #(
  parameter AW = 16 // Word address width
) (
  input  wire logic          clk,        // Clock
  input  wire logic          ready,      // Access accepted
  input  wire logic          rvalid,     // Read valid
  input  wire logic [63:0]   rdata,      // Read data
  input  wire logic [7:0]    recc,       // Read check code
  output var  logic          req,        // Request
  output var  logic          we,         // Write
  output var  logic [AW-1:0] addr,       // Address
  output var  logic          addr_par,   // Address parity
  output var  logic [7:0]    be,         // Byte enables
  output var  logic [63:0]   wdata,      // Write data
  output var  logic [7:0]    wecc,       // Write check code
  output var  logic          evt_single, // Single event
  output var  logic          evt_multi   // Multi event
);
  logic        evt_en; // Event signaling switch
  logic        got_valid;
  logic [63:0] got_data;
  logic [7:0]  got_ecc;

  // Event signaling starts switched off
  initial
  begin
    req = 0; we = 0; addr = '0; addr_par = 0; be = '0; wdata = '0;
    wecc = '0; evt_single = 0; evt_multi = 0;
    evt_en = 0;
  end

  // Released we, addr, wdata and wecc show the inverse, not a stale copy
  function automatic void drop();
    req = 0; we = ~we; addr = ~addr; wdata = ~wdata; wecc = ~wecc;
  endfunction

  task automatic access(input logic w, input logic [AW-1:0] a,
    input logic [7:0] b, input logic [63:0] d, input logic [7:0] e,
    input logic bad);
    begin
      @(negedge clk);
      req = 1; we = w; addr = a; addr_par = (^a) ^ bad;
      be = b; wdata = d; wecc = e;
      @(posedge clk);
      // An endless stall is left to the bench's hang guard
      while (!ready)
        @(posedge clk);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] b,
    input logic [63:0] d, input logic [7:0] e);
    access(1'b1, a, b, d, e, 1'b0);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic bad);
    begin
      access(1'b0, a, 8'h00, 64'h0, 8'h00, bad);
      @(negedge clk);
      got_valid = rvalid; got_data = rdata; got_ecc = recc;
      drop();
    end
  endtask

  task automatic idle();
    @(negedge clk);
    drop();
  endtask

  // No error events leave the CPU unless signaling is on
  task automatic event_pulse(input logic multi);
    begin
      @(negedge clk);
      if (evt_en)
      begin
        if (multi) evt_multi = 1; else evt_single = 1;
      end
      @(negedge clk);
      evt_single = 0; evt_multi = 0;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/test_coupled_ram_wrapper.sv
/*
  Self-checking bench for the coupled RAM wrapper.
  Assumes the design headers on the include path; BW shortened to 4.
*/
`timescale 1ns/1ps
`default_nettype none
`include "coupled_ram_map.vh"
module test_coupled_ram_wrapper;
  localparam AW = 6;
  localparam BW = 4;
  logic clk, rst_n, single_clr, multi_clr, fault_clr, init_start;
  logic req, we, par, evs, evm, rdy, rv, si, mi, pe, de, se, ib, idn, tv, tw;
  logic [AW-1:0] addr, sa, ma, ta;
  logic [7:0]    be, wecc, recc, tbe;
  logic [63:0]   wdata, rdata;
  int miscompares = 0;
  int tests_run = 0;
  int n;

  coupled_ram_wrapper #(.AW(AW), .BW(BW)) i_dut (
    .clk(clk), .rst_n(rst_n), .cpu_req(req), .cpu_we(we),
    .cpu_addr(addr), .cpu_addr_par(par), .cpu_be(be), .cpu_wdata(wdata),
    .cpu_wecc(wecc), .cpu_ready(rdy), .cpu_rvalid(rv), .cpu_rdata(rdata),
    .cpu_recc(recc), .evt_single(evs), .evt_multi(evm),
    .single_clr(single_clr), .multi_clr(multi_clr), .single_irq(si),
    .multi_irq(mi), .single_addr(sa), .multi_addr(ma),
    .fault_clr(fault_clr), .par_err(pe), .dec_err(de), .sys_err(se),
    .init_start(init_start), .init_busy(ib), .init_done(idn),
    .trc_valid(tv), .trc_we(tw), .trc_addr(ta), .trc_be(tbe));

  cpu_port_model #(.AW(AW)) i_cpu (
    .clk(clk), .ready(rdy), .rvalid(rv), .rdata(rdata), .recc(recc),
    .req(req), .we(we), .addr(addr), .addr_par(par), .be(be),
    .wdata(wdata), .wecc(wecc), .evt_single(evs), .evt_multi(evm));

  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_reset();
    chk_bit("ready", 1, rdy);
    chk_bit("rvalid", 0, rv);
    chk_bit("single_irq", 0, si);
    chk_bit("par_err", 0, pe);
    $display("test reset done");
  endtask

  // Back-to-back writes, a lane merge and an out-of-range write
  task automatic t_data();
    i_cpu.wr(1, 8'hFF, 64'h0123_4567_89AB_CDEF, 8'hA5);
    i_cpu.wr(2, 8'hFF, 64'hFEDC_BA98_7654_3210, 8'h3C);
    i_cpu.wr(2, 8'h0F, 64'h1111_2222_3333_4444, 8'h5A);
    i_cpu.wr(6'h11, 8'hF0, 64'h0, 8'h00);
    i_cpu.idle();
    chk_val("trace be", 8'hF0, tbe);
    chk_bit("trace we wr", 1, tw);
    i_cpu.rd(1, 0);
    chk_bit("rvalid", 1, i_cpu.got_valid);
    chk_val("data 1", 64'h0123_4567_89AB_CDEF, i_cpu.got_data);
    chk_val("ecc 1", 8'hA5, i_cpu.got_ecc);
    chk_val("trace addr", 1, ta);
    chk_bit("trace we", 0, tw);
    i_cpu.rd(2, 0);
    chk_val("data 2", 64'hFEDC_BA98_3333_4444, i_cpu.got_data);
    chk_val("ecc 2", 8'h5A, i_cpu.got_ecc);
    $display("test data done");
  endtask

  task automatic t_events();
    i_cpu.event_pulse(0);
    chk_bit("single_irq off", 0, si);
    i_cpu.evt_en = 1;
    i_cpu.rd(2, 0);
    i_cpu.event_pulse(0);
    chk_bit("single_irq", 1, si);
    chk_val("single_addr", 2, sa);
    i_cpu.rd(1, 0);
    i_cpu.event_pulse(1);
    chk_bit("multi_irq", 1, mi);
    chk_val("multi_addr", 1, ma);
    chk_val("single_addr kept", 2, sa);
    @(negedge clk) {single_clr, multi_clr} = 2'b11;
    @(negedge clk) {single_clr, multi_clr} = 2'b00;
    chk_bit("single cleared", 0, si);
    chk_bit("multi cleared", 0, mi);
    $display("test events done");
  endtask

  task automatic t_parity();
    i_cpu.rd(3, 1);
    chk_bit("par_err", 1, pe);
    chk_bit("sys_err", 1, se);
    chk_bit("dec_err", 0, de);
    i_cpu.rd(3, 0);
    chk_bit("par_err sticky", 1, pe);
    @(negedge clk) fault_clr = 1;
    @(negedge clk) fault_clr = 0;
    chk_bit("sys_err cleared", 0, se);
    $display("test parity done");
  endtask

  task automatic t_init();
    @(negedge clk) init_start = 1;
    @(negedge clk) init_start = 0;
    chk_bit("busy", 1, ib);
    chk_bit("ready in init", 0, rdy);
    n = 1;
    while (idn !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk_val("init span", (1 << BW) + 1, n);
    chk_bit("ready after", 1, rdy);
    i_cpu.rd(2, 0);
    chk_val("init data", `INIT_DATA, i_cpu.got_data);
    chk_val("init ecc", `INIT_ECC, i_cpu.got_ecc);
    $display("test init done");
  endtask

  // Free-running clock
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    rst_n = 0; single_clr = 0; multi_clr = 0; fault_clr = 0;
    init_start = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1;
    t_reset();
    t_data();
    t_events();
    t_parity();
    t_init();
    conclude();
  end

  // Hang guard at 5000 cycles, well past the expected few dozen cycles
  initial
  begin
    #(25 * 5000);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
